/* core/ocpwm_consts.svh */
// Register offsets, reset values and fixed codes of the compare channel.
`ifndef OCPWM_CONSTS_SVH
`define OCPWM_CONSTS_SVH
`define OCPWM_OFS_CTRL1      8'h00
`define OCPWM_OFS_CTRL2      8'h04
`define OCPWM_OFS_PRIMARY    8'h08
`define OCPWM_OFS_SECONDARY  8'h0C
`define OCPWM_OFS_PERIOD     8'h10
`define OCPWM_OFS_COUNT      8'h14
`define OCPWM_RST_CTRL1      16'h0000
`define OCPWM_RST_CTRL2      16'h000C
`define OCPWM_RST_VALUE      16'h0000
`define OCPWM_SYNC_NONE      5'h00
`define OCPWM_SYNC_SELF      5'h1F
`define OCPWM_TSEL_SYSCLK    3'h7
`define OCPWM_TSEL_LAST      3'h4
`define OCPWM_FAULT_A_LAST   4
`endif

/* core/ocpwm_pkg.sv */
// Types shared by the output compare and PWM channel.
package ocpwm_pkg;
    typedef enum logic [2:0] {
        OCM_OFF, OCM_SHOT_HIGH, OCM_SHOT_LOW, OCM_TOGGLE,
        OCM_DBL_SHOT, OCM_DBL_CONT, OCM_PWM_EDGE, OCM_PWM_CENTER
    } ocpwm_mode_t;
    typedef enum logic [1:0] {
        OCS_ARMED, OCS_SECOND, OCS_DONE
    } ocpwm_shot_t;
    typedef struct packed {
        logic        idle_halt;
        logic [2:0]  timebase_select;
        logic        fault_input_enable;
        logic        fault_seen_flag;
        logic        trigger_clear_mode;
        ocpwm_mode_t compare_mode_select;
    } ocpwm_ctrl1_t;
    typedef struct packed {
        logic       fault_hold_mode;
        logic       fault_drive_level;
        logic       fault_force_output;
        logic       output_invert;
        logic       cascade_enable;
        logic       trigger_not_sync;
        logic       trigger_running_status;
        logic       pin_tristate;
        logic [4:0] sync_source_select;
    } ocpwm_ctrl2_t;
    typedef struct packed {
        logic [15:0] primary;
        logic [15:0] secondary;
    } ocpwm_duty_t;
endpackage

/* core/ocpwm_channel.sv */
// One output compare channel with PWM, fault, trigger and cascade logic.
//
// Contract
// - Idle-halt set freezes the channel while the processor idles.
// - Timebase selector picks timer 2,3,4,5,1 or system clock; 101,110 none.
// - Fault acts only when enabled; fault sets the flag in both PWM modes.
// - Trigger clear mode lets a secondary match clear trigger running status.
// - Mode 111 is center-aligned PWM, mode 110 edge-aligned PWM.
// - Mode 101 starts low and toggles on alternate primary/secondary matches.
// - Double single-shot starts low, toggles on primary then secondary once.
// - Mode 011 toggles the output on every compare event.
// - Mode 010 starts high, goes low once; mode 001 starts low, goes high.
// - Mode 000 disables the channel.
// - Fault input A serves channels one to four, B five to nine.
// - Compare values are double-buffered only in PWM modes.
// - Hold mode needs software clear; otherwise a new period ends fault.
// - In fault the PWM output takes the fault drive level.
// - Fault force output turns the pin to output during a fault.
// - Output invert inverts the channel output.
// - Cascade enable pairs this channel with its neighbour as 32 bits.
// - Trigger-not-sync picks trigger operation, else sync operation.
// - Trigger running status set by hardware; timer held zero while clear.
// - Pin tristate set releases the pin, else the channel drives it.
// - Sync selector: none, channels, timers, others, self; 1000x reserved.
// - Period value N gives a PWM period of N plus one counts.
// - PWM duty values latch only when the count meets the period.
// - All zero keeps output low; secondary above period keeps it high.
`timescale 1ns/1ps
`include "ocpwm_consts.svh"
module ocpwm_channel
    import ocpwm_pkg::*;
#(
    parameter int CHANNEL_INDEX = 1
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        cpu_idle_i,
    input  wire logic [4:0]  timer_tick_i,
    input  wire logic [31:0] sync_event_i,
    input  wire logic        cascade_carry_i,
    output logic             cascade_carry_o,
    input  wire logic        fault_input_a_i,
    input  wire logic        fault_input_b_i,
    output logic             compare_output_pin_o,
    output logic             compare_output_pin_oe_o
);
    // Register state.
    ocpwm_ctrl1_t ctrl1_ff, nxt_ctrl1;
    ocpwm_ctrl2_t ctrl2_ff, nxt_ctrl2;
    ocpwm_duty_t  duty_ff, nxt_duty;
    ocpwm_duty_t  act_ff, nxt_act;
    logic [15:0]  period_ff, nxt_period;
    logic [15:0]  count_ff, nxt_count;
    ocpwm_shot_t  shot_ff, nxt_shot;
    logic         lvl_ff, nxt_lvl;
    logic [2:0]   flt_sync_ff, nxt_flt_sync;
    logic         flt_lvl_ff, nxt_flt_lvl;
    logic         ack_ff, nxt_ack;
    logic [31:0]  rdat_ff, nxt_rdat;
    logic         pin_ff, nxt_pin;
    logic         oe_ff, nxt_oe;
    logic         carry_ff, nxt_carry;

    // Pack and unpack the control words; unused positions stay zero.
    function automatic logic [15:0] pack1(input ocpwm_ctrl1_t c);
        return {2'h0, c.idle_halt, c.timebase_select, 2'h0,
                c.fault_input_enable, 2'h0, c.fault_seen_flag,
                c.trigger_clear_mode, c.compare_mode_select};
    endfunction

    function automatic ocpwm_ctrl1_t unpack1(input logic [15:0] w);
        return ocpwm_ctrl1_t'({w[13:10], w[7], w[4:0]});
    endfunction

    function automatic logic [15:0] pack2(input ocpwm_ctrl2_t c);
        return {c.fault_hold_mode, c.fault_drive_level,
                c.fault_force_output, c.output_invert, 3'h0,
                c.cascade_enable, c.trigger_not_sync,
                c.trigger_running_status, c.pin_tristate,
                c.sync_source_select};
    endfunction

    function automatic ocpwm_ctrl2_t unpack2(input logic [15:0] w);
        return ocpwm_ctrl2_t'({w[15:12], w[8:0]});
    endfunction

    // Merge a bus write into a 16-bit register by byte lane.
    function automatic logic [15:0] merge(input logic [15:0] old,
                                          input logic [15:0] dat,
                                          input logic [1:0]  sel);
        return {sel[1] ? dat[15:8] : old[15:8],
                sel[0] ? dat[7:0] : old[7:0]};
    endfunction

    // Decoded request and shared control terms.
    logic        req, wr, run, pwm, tick, period_hit, sync_ev, trig_mode;
    logic        fire_p, fire_s, fault_pin, fault_now, pwm_lvl, raw;
    logic        wr_c1, wr_c2;
    logic [15:0] wv_c1, wv_c2;
    ocpwm_mode_t mode;

    assign req = wb_cyc_i & wb_stb_i & ~ack_ff;
    assign wr = req & wb_we_i;
    assign wr_c1 = wr && wb_adr_i == `OCPWM_OFS_CTRL1;
    assign wr_c2 = wr && wb_adr_i == `OCPWM_OFS_CTRL2;
    assign wv_c1 = merge(pack1(ctrl1_ff), wb_dat_i[15:0], wb_sel_i[1:0]);
    assign wv_c2 = merge(pack2(ctrl2_ff), wb_dat_i[15:0], wb_sel_i[1:0]);
    assign mode = ctrl1_ff.compare_mode_select;
    assign pwm = mode == OCM_PWM_EDGE || mode == OCM_PWM_CENTER;
    assign run = ~(ctrl1_ff.idle_halt & cpu_idle_i);
    assign trig_mode = ctrl2_ff.trigger_not_sync &&
                       ctrl2_ff.sync_source_select != `OCPWM_SYNC_NONE;
    assign fault_pin = flt_lvl_ff;

    // Timebase selection; cascade feeds the count from the lower half.
    always_comb begin
        tick = 1'b0;
        if (ctrl2_ff.cascade_enable) begin
            tick = cascade_carry_i;
        end else if (ctrl1_ff.timebase_select == `OCPWM_TSEL_SYSCLK) begin
            tick = 1'b1;
        end else if (ctrl1_ff.timebase_select <= `OCPWM_TSEL_LAST) begin
            tick = timer_tick_i[ctrl1_ff.timebase_select];
        end
    end

    // Period end, sync source event and compare matches.
    always_comb begin
        period_hit = tick && count_ff == period_ff;
        unique case (ctrl2_ff.sync_source_select)
            `OCPWM_SYNC_NONE: sync_ev = 1'b0;
            `OCPWM_SYNC_SELF: sync_ev = period_hit;
            default: sync_ev = sync_event_i[ctrl2_ff.sync_source_select];
        endcase
        fire_p = run && tick && count_ff == act_ff.primary;
        fire_s = run && tick && count_ff == act_ff.secondary;
        fault_now = ctrl1_ff.fault_input_enable && pwm && fault_pin;
    end

    // Fault pin: three stages, a change counts when the last two agree.
    always_comb begin
        nxt_flt_sync = {flt_sync_ff[1:0],
                        (CHANNEL_INDEX <= `OCPWM_FAULT_A_LAST) ?
                        fault_input_a_i : fault_input_b_i};
        nxt_flt_lvl = flt_lvl_ff;
        if (flt_sync_ff[2] == flt_sync_ff[1]) begin
            nxt_flt_lvl = flt_sync_ff[2];
        end
    end

    // Control registers, including the hardware-owned status bits.
    always_comb begin
        nxt_ctrl1 = ctrl1_ff;
        nxt_ctrl2 = ctrl2_ff;
        if (wr_c1) begin
            nxt_ctrl1 = unpack1(wv_c1);
            nxt_ctrl1.fault_seen_flag = ctrl1_ff.fault_seen_flag;
            if (ctrl2_ff.fault_hold_mode && !wv_c1[4] && !fault_pin) begin
                nxt_ctrl1.fault_seen_flag = 1'b0;
            end
        end
        if (wr_c2) begin
            nxt_ctrl2 = unpack2(wv_c2);
        end
        if (run && !ctrl2_ff.fault_hold_mode && period_hit && !fault_pin) begin
            nxt_ctrl1.fault_seen_flag = 1'b0;
        end
        if (fault_now) begin
            nxt_ctrl1.fault_seen_flag = 1'b1;
        end
        if (run && ctrl1_ff.trigger_clear_mode && tick &&
            count_ff == act_ff.secondary) begin
            nxt_ctrl2.trigger_running_status = 1'b0;
        end
        if (run && trig_mode && sync_ev) begin
            nxt_ctrl2.trigger_running_status = 1'b1;
        end
    end

    // Compare value, period and buffered copies.
    always_comb begin
        nxt_duty = duty_ff;
        nxt_period = period_ff;
        if (wr && wb_adr_i == `OCPWM_OFS_PRIMARY) begin
            nxt_duty.primary = merge(duty_ff.primary, wb_dat_i[15:0],
                                     wb_sel_i[1:0]);
        end
        if (wr && wb_adr_i == `OCPWM_OFS_SECONDARY) begin
            nxt_duty.secondary = merge(duty_ff.secondary, wb_dat_i[15:0],
                                       wb_sel_i[1:0]);
        end
        if (wr && wb_adr_i == `OCPWM_OFS_PERIOD) begin
            nxt_period = merge(period_ff, wb_dat_i[15:0], wb_sel_i[1:0]);
        end
        nxt_act = act_ff;
        if (!pwm) begin
            nxt_act = duty_ff;
        end else if (run && period_hit) begin
            nxt_act = duty_ff;
        end
    end

    // Channel timer: held, synced, triggered or counting to the period.
    always_comb begin
        nxt_count = count_ff;
        nxt_carry = 1'b0;
        if (mode == OCM_OFF) begin
            nxt_count = 16'h0000;
        end else if (run) begin
            nxt_carry = period_hit;
            if (trig_mode && !ctrl2_ff.trigger_running_status) begin
                nxt_count = 16'h0000;
            end else if (!ctrl2_ff.trigger_not_sync && sync_ev) begin
                nxt_count = 16'h0000;
            end else if (tick) begin
                nxt_count = period_hit ? 16'h0000 : count_ff + 16'h0001;
            end
        end
    end

    // Compare modes: output level and one-shot progress.
    always_comb begin
        nxt_lvl = lvl_ff;
        nxt_shot = shot_ff;
        if (wr_c1) begin
            nxt_lvl = wv_c1[2:0] == OCM_SHOT_LOW;
            nxt_shot = OCS_ARMED;
        end else begin
            unique case (mode)
                OCM_SHOT_HIGH: if (shot_ff == OCS_ARMED && fire_p) begin
                    nxt_lvl = 1'b1;
                    nxt_shot = OCS_DONE;
                end
                OCM_SHOT_LOW: if (shot_ff == OCS_ARMED && fire_p) begin
                    nxt_lvl = 1'b0;
                    nxt_shot = OCS_DONE;
                end
                OCM_TOGGLE: if (fire_p) begin
                    nxt_lvl = ~lvl_ff;
                end
                OCM_DBL_SHOT: begin
                    if (shot_ff == OCS_ARMED && fire_p) begin
                        nxt_lvl = ~lvl_ff;
                        nxt_shot = OCS_SECOND;
                    end else if (shot_ff == OCS_SECOND && fire_s) begin
                        nxt_lvl = ~lvl_ff;
                        nxt_shot = OCS_DONE;
                    end
                end
                OCM_DBL_CONT: begin
                    if (shot_ff == OCS_ARMED && fire_p) begin
                        nxt_lvl = ~lvl_ff;
                        nxt_shot = OCS_SECOND;
                    end else if (shot_ff == OCS_SECOND && fire_s) begin
                        nxt_lvl = ~lvl_ff;
                        nxt_shot = OCS_ARMED;
                    end
                end
                OCM_OFF: nxt_lvl = 1'b0;
                OCM_PWM_EDGE, OCM_PWM_CENTER: nxt_lvl = lvl_ff;
            endcase
        end
    end

    // PWM level and the pin after fault, invert and direction control.
    always_comb begin
        if (mode == OCM_PWM_CENTER) begin
            pwm_lvl = count_ff >= act_ff.primary &&
                      count_ff < act_ff.secondary;
        end else begin
            pwm_lvl = count_ff < act_ff.secondary;
        end
        raw = pwm ? pwm_lvl : lvl_ff;
        nxt_pin = pin_ff;
        nxt_oe = oe_ff;
        if (run) begin
            nxt_pin = raw ^ ctrl2_ff.output_invert;
            nxt_oe = ~ctrl2_ff.pin_tristate;
            if (pwm && ctrl1_ff.fault_seen_flag) begin
                nxt_pin = ctrl2_ff.fault_drive_level;
                if (ctrl2_ff.fault_force_output) begin
                    nxt_oe = 1'b1;
                end
            end
        end
    end

    // Bus answer: one wait state, unmapped reads return zero.
    always_comb begin
        nxt_ack = req;
        nxt_rdat = 32'h0000_0000;
        if (req && !wb_we_i) begin
            unique case (wb_adr_i)
                `OCPWM_OFS_CTRL1:     nxt_rdat[15:0] = pack1(ctrl1_ff);
                `OCPWM_OFS_CTRL2:     nxt_rdat[15:0] = pack2(ctrl2_ff);
                `OCPWM_OFS_PRIMARY:   nxt_rdat[15:0] = duty_ff.primary;
                `OCPWM_OFS_SECONDARY: nxt_rdat[15:0] = duty_ff.secondary;
                `OCPWM_OFS_PERIOD:    nxt_rdat[15:0] = period_ff;
                `OCPWM_OFS_COUNT:     nxt_rdat[15:0] = count_ff;
                default:              nxt_rdat = 32'h0000_0000;
            endcase
        end
    end

    // All state registers.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl1_ff <= unpack1(`OCPWM_RST_CTRL1);
            ctrl2_ff <= unpack2(`OCPWM_RST_CTRL2);
            duty_ff <= {`OCPWM_RST_VALUE, `OCPWM_RST_VALUE};
            act_ff <= {`OCPWM_RST_VALUE, `OCPWM_RST_VALUE};
            period_ff <= `OCPWM_RST_VALUE;
            count_ff <= `OCPWM_RST_VALUE;
            shot_ff <= OCS_ARMED;
            lvl_ff <= 1'b0;
            flt_sync_ff <= 3'h0;
            flt_lvl_ff <= 1'b0;
            ack_ff <= 1'b0;
            rdat_ff <= 32'h0000_0000;
            pin_ff <= 1'b0;
            oe_ff <= 1'b1;
            carry_ff <= 1'b0;
        end else begin
            ctrl1_ff <= nxt_ctrl1;
            ctrl2_ff <= nxt_ctrl2;
            duty_ff <= nxt_duty;
            act_ff <= nxt_act;
            period_ff <= nxt_period;
            count_ff <= nxt_count;
            shot_ff <= nxt_shot;
            lvl_ff <= nxt_lvl;
            flt_sync_ff <= nxt_flt_sync;
            flt_lvl_ff <= nxt_flt_lvl;
            ack_ff <= nxt_ack;
            rdat_ff <= nxt_rdat;
            pin_ff <= nxt_pin;
            oe_ff <= nxt_oe;
            carry_ff <= nxt_carry;
        end
    end

    // Outputs straight from flip-flops.
    assign wb_ack_o = ack_ff;
    assign wb_dat_o = rdat_ff;
    assign compare_output_pin_o = pin_ff;
    assign compare_output_pin_oe_o = oe_ff;
    assign cascade_carry_o = carry_ff;
endmodule

/* dv/ocpwm_asserts.sv */
// Assertion checker watching the compare channel bus and pin ports.
`timescale 1ns/1ps
`include "ocpwm_consts.svh"
module ocpwm_asserts (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_o,
    input  wire logic        wb_ack_o,
    input  wire logic        compare_output_pin_o,
    input  wire logic        compare_output_pin_oe_o
);
    // All checks share the bus clock; all but AST_RESET_OUT are quiet during reset.
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic rd_ack;
    // A read answer is any ack seen while write enable is low.
    assign rd_ack = wb_ack_o && !wb_we_i;
    AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=>
        wb_ack_o) else $error("ack missing after a taken request");
    AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without a request");
    AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data not zero outside ack");
    AST_DAT_UPPER: assert property (rd_ack |-> wb_dat_o[31:16] == 16'h0)
        else $error("upper read data not zero");
    AST_CTRL1_BITS: assert property (rd_ack && wb_adr_i == `OCPWM_OFS_CTRL1
        |-> (wb_dat_o[15:0] & 16'hC360) == 16'h0)
        else $error("unimplemented control one bit read as one");
    AST_CTRL2_BITS: assert property (rd_ack && wb_adr_i == `OCPWM_OFS_CTRL2
        |-> (wb_dat_o[15:0] & 16'h0E00) == 16'h0)
        else $error("unimplemented control two bit read as one");
    AST_UNMAPPED: assert property (rd_ack && wb_adr_i > `OCPWM_OFS_COUNT
        |-> wb_dat_o == 32'h0) else $error("unmapped read not zero");
    AST_RESET_OUT: assert property (disable iff (1'b0) rst_i |=>
        !wb_ack_o && !compare_output_pin_o && compare_output_pin_oe_o)
        else $error("outputs wrong after reset");
endmodule

bind ocpwm_channel ocpwm_asserts u_asserts (
    .clk_i                   (clk_i),
    .rst_i                   (rst_i),
    .wb_cyc_i                (wb_cyc_i),
    .wb_stb_i                (wb_stb_i),
    .wb_we_i                 (wb_we_i),
    .wb_adr_i                (wb_adr_i),
    .wb_dat_o                (wb_dat_o),
    .wb_ack_o                (wb_ack_o),
    .compare_output_pin_o    (compare_output_pin_o),
    .compare_output_pin_oe_o (compare_output_pin_oe_o)
);

/* dv/testbench.sv */
// Self-checking testbench of the output compare and PWM channel.
`timescale 1ns/1ps
`include "ocpwm_consts.svh"
module testbench;
    logic        clk_i, rst_i, cyc, stb, we, idle, carry, flt_a, flt_b;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [4:0]  tick;
    logic [31:0] wdat, rdat, sev;
    wire  logic [31:0] dat_o;
    wire  logic        ack, carry_o, pin, oe;
    int          errors, total_checks, cycles, hi, tg, cr, c0;
    logic        prev;

    ocpwm_channel #(.CHANNEL_INDEX(1)) dut (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .cpu_idle_i(idle), .timer_tick_i(tick), .sync_event_i(sev),
        .cascade_carry_i(carry), .cascade_carry_o(carry_o),
        .fault_input_a_i(flt_a), .fault_input_b_i(flt_b),
        .compare_output_pin_o(pin), .compare_output_pin_oe_o(oe));

    // Free-running 40 MHz clock.
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    // Cycle ceiling that cuts a hang short.
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        if (errors == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic check(input string n, input logic [31:0] e, g);
        total_checks++;
        if (g !== e) begin
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
            errors++;
        end
    endtask

    // One classic Wishbone cycle, held until ack is sampled.
    task automatic bus(input logic [7:0] a, input logic w, input logic [15:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {16'h0000, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 40);
        rdat = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        check("ack", 1, ack);
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] e, string n);
        bus(a, 1'b0, 16'h0000);
        check(n, e, rdat);
    endtask

    // Channel set up with the mode written last.
    task automatic cfg(input logic [15:0] c1, c2, p, s, per);
        bus(`OCPWM_OFS_CTRL1, 1'b1, 16'h0000);
        bus(`OCPWM_OFS_PRIMARY, 1'b1, p);
        bus(`OCPWM_OFS_SECONDARY, 1'b1, s);
        bus(`OCPWM_OFS_PERIOD, 1'b1, per);
        bus(`OCPWM_OFS_CTRL2, 1'b1, c2);
        bus(`OCPWM_OFS_CTRL1, 1'b1, c1);
    endtask

    // Counts high cycles, pin toggles and carry pulses over n cycles.
    task automatic watch(input int n);
        prev = pin;
        hi = 0;
        tg = 0;
        cr = 0;
        repeat (n) begin
            @(posedge clk_i);
            hi += (pin === 1'b1);
            tg += (pin !== prev);
            cr += (carry_o === 1'b1);
            prev = pin;
        end
    endtask

    task automatic pwm(input logic [15:0] c1, c2, p, s, per, input int e);
        cfg(c1, c2, p, s, per);
        watch(30);
        watch(20);
        check("pwm high", e, hi);
    endtask

    task automatic t_regs();
        rchk(`OCPWM_OFS_CTRL1, `OCPWM_RST_CTRL1, "ctrl1 rst");
        rchk(`OCPWM_OFS_CTRL2, `OCPWM_RST_CTRL2, "ctrl2 rst");
        bus(8'h18, 1'b1, 16'hFFFF);
        rchk(8'h18, 32'h0, "unmapped");
        bus(`OCPWM_OFS_COUNT, 1'b1, 16'h1234);
        rchk(`OCPWM_OFS_COUNT, 32'h0, "count off");
        bus(`OCPWM_OFS_CTRL1, 1'b1, 16'hFFFF);
        rchk(`OCPWM_OFS_CTRL1, 32'h3C8F, "ctrl1 bits");
        bus(`OCPWM_OFS_CTRL1, 1'b1, 16'h0000);
        bus(`OCPWM_OFS_CTRL2, 1'b1, 16'hFFFF);
        rchk(`OCPWM_OFS_CTRL2, 32'hF1FF, "ctrl2 bits");
        bus(`OCPWM_OFS_CTRL2, 1'b1, 16'h000C);
    endtask

    task automatic t_shot();
        for (int m = 1; m <= 2; m++) begin
            cfg(16'h1C00 | 16'(m), 16'h0, 16'd15, 16'h0, 16'd40);
            watch(3);
            check("shot start", (m == 2) ? 3 : 0, hi);
            watch(60);
            check("shot end", m == 1, pin);
            watch(60);
            check("shot once", (m == 1) ? 60 : 0, hi);
        end
        cfg(16'h1C04, 16'h0, 16'd5, 16'd10, 16'd40);
        watch(63);
        check("dbl shot", 5, hi);
        watch(60);
        check("dbl once", 0, hi);
        pwm(16'h1C05, 16'h0, 16'd2, 16'd6, 16'd9, 8);
    endtask

    task automatic t_pwm();
        pwm(16'h1C06, 16'h0, 16'd0, 16'd4, 16'd9, 8);
        pwm(16'h1C07, 16'h0, 16'd2, 16'd6, 16'd9, 8);
        pwm(16'h1C06, 16'h0, 16'd0, 16'd20, 16'd9, 20);
        pwm(16'h1C06, 16'h0, 16'd0, 16'd0, 16'd0, 0);
        pwm(16'h1C06, 16'h1000, 16'd0, 16'd4, 16'd9, 12);
    endtask

    task automatic t_fault();
        cfg(16'h1C86, 16'h6020, 16'd0, 16'd4, 16'd9);
        watch(20);
        check("oe tri", 0, oe);
        flt_b <= 1'b1;
        watch(20);
        rchk(`OCPWM_OFS_CTRL1, 32'h1C86, "flag b");
        flt_b <= 1'b0;
        flt_a <= 1'b1;
        watch(20);
        watch(20);
        check("fault high", 20, hi);
        check("fault oe", 1, oe);
        rchk(`OCPWM_OFS_CTRL1, 32'h1C96, "flag a");
        flt_a <= 1'b0;
        watch(40);
        rchk(`OCPWM_OFS_CTRL1, 32'h1C86, "flag clear");
        check("oe back", 0, oe);
        bus(`OCPWM_OFS_CTRL1, 1'b1, 16'h1C06);
        flt_a <= 1'b1;
        watch(20);
        rchk(`OCPWM_OFS_CTRL1, 32'h1C06, "flag off");
        flt_a <= 1'b0;
        cfg(16'h1C86, 16'hC000, 16'd0, 16'd4, 16'd9);
        flt_a <= 1'b1;
        watch(10);
        flt_a <= 1'b0;
        watch(40);
        rchk(`OCPWM_OFS_CTRL1, 32'h1C96, "flag held");
        bus(`OCPWM_OFS_CTRL1, 1'b1, 16'h1C86);
        rchk(`OCPWM_OFS_CTRL1, 32'h1C86, "flag sw clear");
    endtask

    // Direct and buffered compare values, then a sync reset of the count.
    task automatic t_buf();
        cfg(16'h1C03, 16'h0, 16'd150, 16'h0, 16'd199);
        bus(`OCPWM_OFS_PRIMARY, 1'b1, 16'd40);
        watch(60);
        check("direct", 1, tg);
        cfg(16'h1C06, 16'h0, 16'd0, 16'd2, 16'd199);
        bus(`OCPWM_OFS_SECONDARY, 1'b1, 16'd100);
        watch(20);
        check("buffered", 0, hi);
        watch(200);
        check("latched", 1, pin);
        cfg(16'h1C03, 16'h0002, 16'd3, 16'h0, 16'hFFFF);
        watch(20);
        sev <= 32'h4;
        @(posedge clk_i);
        sev <= 32'h0;
        rchk(`OCPWM_OFS_COUNT, 32'h1, "sync reset");
    endtask

    task automatic t_trig();
        cfg(16'h1C03, 16'h0082, 16'd3, 16'd5, 16'd30);
        watch(10);
        rchk(`OCPWM_OFS_COUNT, 32'h0, "held");
        sev <= 32'h4;
        @(posedge clk_i);
        sev <= 32'h0;
        watch(60);
        rchk(`OCPWM_OFS_CTRL2, 32'h00C2, "trig run");
        bus(`OCPWM_OFS_CTRL1, 1'b1, 16'h1C0B);
        watch(40);
        rchk(`OCPWM_OFS_CTRL2, 32'h0082, "trig clr");
        rchk(`OCPWM_OFS_COUNT, 32'h0, "held again");
    endtask

    task automatic t_count();
        for (int i = 0; i <= 5; i++) begin
            cfg(16'h0003 | (16'(i) << 10), 16'h0, 16'd3, 16'h0, 16'hFFFF);
            bus(`OCPWM_OFS_COUNT, 1'b0, 16'h0000);
            c0 = rdat;
            tick <= ~(5'h01 << i);
            repeat (4) @(posedge clk_i);
            tick <= 5'h01 << i;
            repeat (3) @(posedge clk_i);
            tick <= 5'h00;
            rchk(`OCPWM_OFS_COUNT, c0 + ((i < 5) ? 3 : 0), "tick");
        end
        cfg(16'h1C03, 16'h0100, 16'd3, 16'h0, 16'hFFFF);
        bus(`OCPWM_OFS_COUNT, 1'b0, 16'h0000);
        c0 = rdat;
        carry <= 1'b1;
        repeat (2) @(posedge clk_i);
        carry <= 1'b0;
        rchk(`OCPWM_OFS_COUNT, c0 + 2, "cascade");
    endtask

    task automatic t_idle();
        cfg(16'h3C03, 16'h0, 16'd3, 16'h0, 16'd9);
        idle <= 1'b1;
        watch(40);
        check("halted", 0, tg);
        idle <= 1'b0;
        watch(40);
        check("toggles", 4, tg);
        check("carry", 4, cr);
        bus(`OCPWM_OFS_CTRL1, 1'b1, 16'h1C03);
        idle <= 1'b1;
        watch(40);
        check("idle run", 4, tg);
        idle <= 1'b0;
    endtask

    // Reset, then the scenarios in turn.
    initial begin
        {rst_i, cyc, stb, we, idle, carry, flt_a, flt_b} = 8'h80;
        {adr, tick, wdat, sev} = '0;
        sel = 4'h3;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_shot();
        t_pwm();
        t_fault();
        t_trig();
        t_count();
        t_idle();
        t_buf();
        end_of_test();
    end
endmodule
